// ==== hdl/vfm_defs.svh ====
// constants for the rail fault and power-state manager
// assumes a 40 ns system clock and a 5 mV reference step
`ifndef VFM_DEFS_SVH
`define VFM_DEFS_SVH

// ****************************************
// clock and timing
// ****************************************
`define VFM_CLK_NS 40
`define VFM_EN_FILT_NS 250
`define VFM_OC_DELAY_US 256
`define VFM_PS_DELAY_TICKS 8
`define VFM_OL_TICKS 8
`define VFM_PWM_DIV 50

// ****************************************
// reference levels
// ****************************************
`define VFM_DAC_W 9
`define VFM_DAC_LSB_MV 5
`define VFM_FLOOR_MV 250
`define VFM_TEST_MV 1000
`define VFM_BOOT0_MV 900
`define VFM_BOOT1_MV 1500

// ****************************************
// state widths
// ****************************************
`define VFM_OC_CNT_W 13
`define VFM_DIV_W 16
`define VFM_SYNC_W 16

`endif

// ==== hdl/vfm_pkg.sv ====
// types for the rail fault and power-state manager
// assumes vfm_defs.svh is on the include path
`include "vfm_defs.svh"

package vfm_pkg;

  // only two power states exist; deep sleep is not built
  typedef enum logic [1:0] {
    PS_FULL  = 2'b00,
    PS_LIGHT = 2'b01
  } vfm_pwr_t;

  typedef struct packed {
    logic [`VFM_SYNC_W-1:0] s1;
    logic [`VFM_SYNC_W-1:0] s2;
    logic [`VFM_DIV_W-1:0] div;
    logic tick;
    logic [2:0] en_cnt;
    logic en_f;
    logic [1:0] strap_cnt;
    logic test_mode;
    vfm_pwr_t ps;
    logic [3:0] ps_cnt;
    logic [1:0] ol_lat;
    logic [1:0] os_lat;
    logic [1:0] ov_lat;
    logic [1:0] oc_lat;
    logic [1:0] pre_done;
    logic [1:0][3:0] ea_cnt;
    logic [1:0][`VFM_OC_CNT_W-1:0] oc_cnt;
    logic [1:0][`VFM_DAC_W-1:0] dac;
    logic [1:0] rdy;
    logic [1:0] ovp;
    logic [1:0] ea_en;
  } vfm_state_t;

endpackage

// ==== hdl/vfm_top.sv ====
// rail fault latches, enable filter, reference ramp and power state
// assumes comparator inputs are asynchronous, command inputs are on clk_i
`timescale 1ns/1ps
`include "vfm_defs.svh"

module vfm_top
  import vfm_pkg::*;
#(
  parameter int PWM_DIV = `VFM_PWM_DIV,
  parameter int OC_DELAY_CYC = `VFM_OC_DELAY_US * 1000 / `VFM_CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic input_rail_monitor_i,
  input wire logic vcc_ok_i,
  input wire logic addr_strap_i,
  input wire logic [1:0] overvoltage_i,
  input wire logic [1:0] overcurrent_i,
  input wire logic [1:0] error_amp_output_high_i,
  input wire logic [1:0] sense_high_imp_i,
  input wire logic [1:0] sense_abnormal_i,
  input wire logic [1:0] output_undervoltage_fault_i,
  input wire logic [1:0] bus_fault_i,
  input wire logic light_load_cmd_i,
  output logic [1:0] regulator_ready_out_o,
  output logic [1:0] overvoltage_indicator_pin_o,
  output logic [1:0] error_amp_enable_o,
  output logic [1:0][`VFM_DAC_W-1:0] reference_dac_level_o,
  output logic single_phase_o,
  output logic light_load_state_o,
  output logic platform_test_o
);

  // ****************************************
  // derived constants
  // ****************************************
  localparam int EN_CYC = (`VFM_EN_FILT_NS + `VFM_CLK_NS - 1) / `VFM_CLK_NS;
  localparam int DW = `VFM_DAC_W;
  localparam logic [DW-1:0] FLOOR =
    DW'(`VFM_FLOOR_MV / `VFM_DAC_LSB_MV);
  localparam logic [DW-1:0] TEST_CODE =
    DW'(`VFM_TEST_MV / `VFM_DAC_LSB_MV);
  localparam logic [DW-1:0] BOOT0 = DW'(`VFM_BOOT0_MV / `VFM_DAC_LSB_MV);
  localparam logic [DW-1:0] BOOT1 = DW'(`VFM_BOOT1_MV / `VFM_DAC_LSB_MV);
  localparam logic [`VFM_DIV_W-1:0] DIV_TOP = `VFM_DIV_W'(PWM_DIV - 1);
  localparam logic [`VFM_OC_CNT_W-1:0] OC_TOP =
    `VFM_OC_CNT_W'(OC_DELAY_CYC - 1);
  localparam logic [2:0] EN_TOP = 3'(EN_CYC - 1);
  localparam logic [3:0] PS_TOP = 4'(`VFM_PS_DELAY_TICKS - 1);
  localparam logic [3:0] OL_TOP = 4'(`VFM_OL_TICKS - 1);

  if (PWM_DIV < 1 || PWM_DIV > 65536) begin : g_bad_div
    $error("PWM_DIV out of range");
  end
  if (OC_DELAY_CYC < 1 || OC_DELAY_CYC > 8192) begin : g_bad_oc
    $error("OC_DELAY_CYC out of range");
  end

  // ****************************************
  // synchroniser bit positions
  // ****************************************
  localparam int S_EN = 0;
  localparam int S_VIN = 1;
  localparam int S_VCC = 2;
  localparam int S_ADDR = 3;
  localparam int S_OV = 4;
  localparam int S_OC = 6;
  localparam int S_EAH = 8;
  localparam int S_HIZ = 10;
  localparam int S_ABN = 12;
  localparam int S_UV = 14;

  vfm_state_t q;
  vfm_state_t d;
  logic [`VFM_SYNC_W-1:0] raw;
  logic stop_all;
  logic [1:0] halt;
  logic en_rise;

  assign raw = {output_undervoltage_fault_i, sense_abnormal_i,
                sense_high_imp_i, error_amp_output_high_i, overcurrent_i,
                overvoltage_i, addr_strap_i, vcc_ok_i,
                input_rail_monitor_i, enable_i};

  // a fault on either rail other than overcurrent, undervoltage or bus
  // stops both rails
  assign stop_all = (|q.ol_lat) | (|q.os_lat) | (|q.ov_lat) | !q.en_f |
                    !(&q.pre_done) |
                    !q.s2[S_VIN] | !q.s2[S_VCC];
  assign halt = {2{stop_all}} | q.oc_lat;
  assign en_rise = !q.en_f & q.s2[S_EN] & (q.en_cnt == EN_TOP);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [DW-1:0] tgt;
    logic oc_trig;
    tgt = FLOOR;
    oc_trig = 1'b0;
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    // switching-cycle enable
    d.tick = (q.div == DIV_TOP);
    d.div = d.tick ? '0 : q.div + 1'b1;
    // enable filter: a level must hold EN_CYC cycles to be taken
    if (q.s2[S_EN] == q.en_f) begin
      d.en_cnt = '0;
    end else if (q.en_cnt == EN_TOP) begin
      d.en_cnt = '0;
      d.en_f = q.s2[S_EN];
    end else begin
      d.en_cnt = q.en_cnt + 1'b1;
    end
    // strap caught once the synchroniser has filled
    if (q.strap_cnt != 2'h3) begin
      d.strap_cnt = q.strap_cnt + 1'b1;
      if (q.strap_cnt == 2'h2) begin
        d.test_mode = q.s2[S_ADDR];
      end
    end
    // power state; no deep state can be reached
    unique case (q.ps)
      PS_FULL: begin
        if (!light_load_cmd_i) begin
          d.ps_cnt = '0;
        end else if (q.tick) begin
          if (q.ps_cnt == PS_TOP) begin
            d.ps = PS_LIGHT;
            d.ps_cnt = '0;
          end else begin
            d.ps_cnt = q.ps_cnt + 1'b1;
          end
        end
      end
      PS_LIGHT: begin
        if (!light_load_cmd_i) begin
          d.ps = PS_FULL;
        end
      end
    endcase
    // per rail, identical logic except the boot target
    for (int r = 0; r < 2; r++) begin
      tgt = q.test_mode ? TEST_CODE : (r == 0 ? BOOT0 : BOOT1);
      // open loop counted in switching cycles
      if (!q.s2[S_EAH+r] || !q.ea_en[r]) begin
        d.ea_cnt[r] = '0;
      end else if (q.tick) begin
        if (q.ea_cnt[r] == OL_TOP) begin
          d.ol_lat[r] = 1'b1;
        end else begin
          d.ea_cnt[r] = q.ea_cnt[r] + 1'b1;
        end
      end
      // sense lines: checked at the first enable after reset only, rechecked on sense abnormal
      if (q.en_f) begin
        d.pre_done[r] = 1'b1;
      end
      if (q.s2[S_HIZ+r] &&
          ((q.en_f && !q.pre_done[r]) || q.s2[S_ABN+r])) begin
        d.os_lat[r] = 1'b1;
      end
      // overvoltage: set wins over the enable-cycle clear
      d.ov_lat[r] = q.s2[S_OV+r] | (q.ov_lat[r] & !en_rise);
      d.ovp[r] = q.ov_lat[r] & q.s2[S_OV+r];
      // overcurrent: delayed in soft start, immediate once ready
      if (!q.s2[S_OC+r] || q.oc_lat[r]) begin
        d.oc_cnt[r] = '0;
      end else if (q.rdy[r] || q.oc_cnt[r] == OC_TOP) begin
        oc_trig = 1'b1;
      end else begin
        d.oc_cnt[r] = q.oc_cnt[r] + 1'b1;
      end
      // released at the floor so soft start runs again
      d.oc_lat[r] = oc_trig |
                    (q.oc_lat[r] & (q.dac[r] != FLOOR));
      oc_trig = 1'b0;
      // amplifier off on any fault except undervoltage and bus
      d.ea_en[r] = !halt[r];
      // reference ramp; undervoltage does not touch it
      if (q.tick) begin
        if (halt[r]) begin
          if (q.dac[r] > FLOOR) begin
            d.dac[r] = q.dac[r] - 1'b1;
          end
        end else if (q.dac[r] < tgt) begin
          d.dac[r] = q.dac[r] + 1'b1;
        end else if (q.dac[r] > tgt) begin
          d.dac[r] = q.dac[r] - 1'b1;
        end
      end
      // bus faults never reach ready
      d.rdy[r] = !halt[r] & !q.s2[S_UV+r] & !q.oc_lat[r] &
                 (q.dac[r] == tgt);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.dac <= {2{FLOOR}};
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign regulator_ready_out_o = q.rdy;
  assign overvoltage_indicator_pin_o = q.ovp;
  assign error_amp_enable_o = q.ea_en;
  assign reference_dac_level_o = q.dac;
  assign single_phase_o = q.ps[0];
  assign light_load_state_o = q.ps[0];
  assign platform_test_o = q.test_mode;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_en_low_held;
    !q.s2[S_EN] [*7];
  endsequence

  a_en_filter: assert property (
    $fell(q.en_f) |-> $past(!q.s2[S_EN]) && $past(q.en_cnt) == EN_TOP)
    else $error("enable filter fell early");
  a_en_blank: assert property (
    q.en_f && q.s2[S_EN] ##1 !q.s2[S_EN] [*3] ##1 q.s2[S_EN] |-> q.en_f)
    else $error("enable fault on short glitch");
  a_en_taken: assert property (
    q.en_f ##0 s_en_low_held |=> !q.en_f)
    else $error("enable low not taken");
  a_ps_delay: assert property (
    q.ps == PS_FULL && q.ps_cnt < PS_TOP |=> q.ps == PS_FULL)
    else $error("light load entered early");
  a_ps_enter: assert property (
    q.ps == PS_FULL && light_load_cmd_i && q.tick && q.ps_cnt == PS_TOP
    |=> single_phase_o)
    else $error("light load not entered");

  for (genvar r = 0; r < 2; r++) begin : g_chk
    a_ol_latch: assert property (
      q.tick && q.ea_en[r] && q.s2[S_EAH+r] && q.ea_cnt[r] == OL_TOP
      |=> q.ol_lat[r] ##1 !q.ea_en[r])
      else $error("open loop not latched");
    a_perm_hold: assert property (
      q.ol_lat[r] || q.os_lat[r] |=> q.ol_lat[r] || q.os_lat[r])
      else $error("permanent fault released");
    a_ov_clear: assert property (
      q.ov_lat[r] && !q.s2[S_OV+r] && en_rise |=> !q.ov_lat[r])
      else $error("overvoltage not cleared by enable");
    a_ovp_only: assert property (
      q.ovp[r] |-> $past(q.ov_lat[r]) && $past(q.s2[S_OV+r]))
      else $error("overvoltage pin without overvoltage");
    a_fault_off: assert property (
      halt[r] |=> !q.ea_en[r] && !q.rdy[r])
      else $error("amplifier or ready on during fault");
    a_uv_ready: assert property (
      q.s2[S_UV+r] |=> !q.rdy[r])
      else $error("ready high during undervoltage");
    a_dac_ramp: assert property (
      halt[r] && q.tick && q.dac[r] > FLOOR
      |=> q.dac[r] == $past(q.dac[r]) - 1'b1)
      else $error("reference not ramping down");
    a_oc_hiccup: assert property (
      q.oc_lat[r] && q.dac[r] == FLOOR |=> !q.oc_lat[r])
      else $error("overcurrent not released at floor");
  end

endmodule

// ==== testbench/vfm_proc_model.sv ====
// processor model driving the power-state command
// assumes commands change at the falling clock edge
`timescale 1ns/1ps
module vfm_proc_model (
  input wire logic clk_i,
  output logic light_load_cmd_o
);
  initial light_load_cmd_o = 1'b0;
  // only full or light load is ever asked
  task automatic issue(input logic light);
    @(negedge clk_i);
    light_load_cmd_o = light;
  endtask
endmodule

// ==== testbench/vfm_top_tb.sv ====
// self-checking bench for the rail fault and power-state manager
// assumes short PWM_DIV and OC_DELAY_CYC so ramps stay brief
`timescale 1ns/1ps
`include "vfm_defs.svh"
module vfm_top_tb;
  import vfm_pkg::*;
  localparam int DIV = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic enable_i = 1'b1;
  logic input_rail_monitor_i = 1'b1;
  logic vcc_ok_i = 1'b1;
  logic addr_strap_i = 1'b0;
  logic light_load_cmd_i;
  logic [1:0] overvoltage_i = 2'h0, overcurrent_i = 2'h0;
  logic [1:0] error_amp_output_high_i = 2'h0, sense_high_imp_i = 2'h0;
  logic [1:0] sense_abnormal_i = 2'h0, output_undervoltage_fault_i = 2'h0;
  // bus faults must change nothing, so they stay raised
  logic [1:0] bus_fault_i = 2'h3;
  logic [1:0] regulator_ready_out_o, overvoltage_indicator_pin_o;
  logic [1:0] error_amp_enable_o;
  logic [1:0][`VFM_DAC_W-1:0] reference_dac_level_o;
  logic single_phase_o, light_load_state_o, platform_test_o;
  int fails = 0;
  int checks_done = 0;

  always #20 clk_i = ~clk_i;

  vfm_proc_model u_vfm_proc_model (
    .clk_i, .light_load_cmd_o(light_load_cmd_i));
  vfm_top #(.PWM_DIV(DIV), .OC_DELAY_CYC(20)) u_vfm_top (
    .clk_i, .rst_n_i, .enable_i, .input_rail_monitor_i, .vcc_ok_i,
    .addr_strap_i, .overvoltage_i, .overcurrent_i,
    .error_amp_output_high_i, .sense_high_imp_i, .sense_abnormal_i,
    .output_undervoltage_fault_i, .bus_fault_i, .light_load_cmd_i,
    .regulator_ready_out_o, .overvoltage_indicator_pin_o,
    .error_amp_enable_o, .reference_dac_level_o, .single_phase_o,
    .light_load_state_o, .platform_test_o);

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // bounded waits; ramps take about a thousand clocks
  task automatic wait_rdy(input logic [1:0] v);
    for (int i = 0; i < 3000 && regulator_ready_out_o !== v; i++) cyc(1);
    check(regulator_ready_out_o, v);
  endtask
  task automatic wait_ref(input int r);
    for (int i = 0; i < 3000 && reference_dac_level_o[r] !== 9'h032; i++)
      cyc(1);
    check(reference_dac_level_o[r], 9'h032);
  endtask
  task automatic rst_pulse();
    rst_n_i = 1'b0;
    cyc(2);
    rst_n_i = 1'b1;
  endtask
  task automatic power_up();
    rst_pulse();
    wait_rdy(2'h3);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_boot();
    power_up();
    check(reference_dac_level_o[0], 9'h0B4);
    check(reference_dac_level_o[1], 9'h12C);
    check(error_amp_enable_o, 2'h3);
    check(platform_test_o, 1'h0);
  endtask
  task automatic t_light();
    u_vfm_proc_model.issue(1'b1);
    cyc(7 * DIV);
    check(single_phase_o, 1'h0);
    cyc(DIV);
    check({single_phase_o, light_load_state_o}, 2'h3);
    u_vfm_proc_model.issue(1'b0);
    cyc(3);
    check(single_phase_o, 1'h0);
  endtask
  task automatic t_ov();
    enable_i = 1'b0;
    cyc(3);
    enable_i = 1'b1;
    cyc(10);
    check(regulator_ready_out_o, 2'h3);
    overvoltage_i = 2'h1;
    cyc(6);
    check(overvoltage_indicator_pin_o, 2'h1);
    check(error_amp_enable_o, 2'h0);
    check(regulator_ready_out_o, 2'h0);
    wait_ref(0);
    wait_ref(1);
    overvoltage_i = 2'h0;
    cyc(6);
    check(overvoltage_indicator_pin_o, 2'h0);
    check(regulator_ready_out_o, 2'h0);
    check(reference_dac_level_o[0], 9'h032);
    enable_i = 1'b0;
    cyc(20);
    enable_i = 1'b1;
    wait_rdy(2'h3);
  endtask
  task automatic t_uv();
    output_undervoltage_fault_i = 2'h1;
    cyc(6);
    check(regulator_ready_out_o, 2'h2);
    check(error_amp_enable_o, 2'h3);
    check(reference_dac_level_o[0], 9'h0B4);
    output_undervoltage_fault_i = 2'h0;
    wait_rdy(2'h3);
  endtask
  task automatic t_oc();
    overcurrent_i = 2'h2;
    cyc(6);
    check(regulator_ready_out_o, 2'h1);
    check(error_amp_enable_o, 2'h1);
    wait_ref(1);
    overcurrent_i = 2'h0;
    cyc(8);
    // short soft-start surge must be ridden out, not latched
    overcurrent_i = 2'h2;
    cyc(10);
    overcurrent_i = 2'h0;
    cyc(3);
    check(error_amp_enable_o, 2'h3);
    // a surge outlasting the delay in soft start must latch
    overcurrent_i = 2'h2;
    cyc(30);
    check(error_amp_enable_o, 2'h1);
    overcurrent_i = 2'h0;
    wait_rdy(2'h3);
  endtask
  task automatic t_ol();
    error_amp_output_high_i = 2'h2;
    cyc(4 * DIV);
    error_amp_output_high_i = 2'h0;
    cyc(6);
    check(regulator_ready_out_o, 2'h3);
    error_amp_output_high_i = 2'h2;
    cyc(10 * DIV);
    error_amp_output_high_i = 2'h0;
    cyc(200);
    check(regulator_ready_out_o, 2'h0);
    check(error_amp_enable_o, 2'h0);
  endtask
  task automatic t_sense();
    power_up();
    sense_abnormal_i = 2'h1;
    sense_high_imp_i = 2'h1;
    cyc(6);
    sense_abnormal_i = 2'h0;
    sense_high_imp_i = 2'h2;
    cyc(200);
    check(regulator_ready_out_o, 2'h0);
    rst_pulse();
    cyc(1500);
    check(regulator_ready_out_o, 2'h0);
  endtask
  task automatic t_test();
    sense_high_imp_i = 2'h0;
    addr_strap_i = 1'b1;
    power_up();
    check(platform_test_o, 1'h1);
    check(reference_dac_level_o[0], 9'h0C8);
    check(reference_dac_level_o[1], 9'h0C8);
  endtask

  initial begin
    t_boot();
    t_light();
    t_ov();
    t_uv();
    t_oc();
    t_ol();
    t_sense();
    t_test();
    tally_and_finish();
  end
  // whole run is near nine thousand clocks
  initial begin
    #(60000 * 40);
    fails++;
    tally_and_finish();
  end
endmodule
